// ### logic/psd_pkg.sv
// Package for the pulse-width modulator and switch driver.
// Assumes a single 20 MHz clock and rate ticks that are synchronous to it.

package psd_pkg;

   // ------------------------------------------------------------
   // Register layouts
   // ------------------------------------------------------------

   // Control register, most significant field first; low six bits are unused.
   typedef struct packed {
      logic       modulator_enable;
      logic [2:0] input_rate_select;
      logic       switch_a_high_drive;
      logic       switch_a_low_drive;
      logic       switch_b_high_drive;
      logic       switch_b_low_drive;
      logic       first_changeover_drive;
      logic       second_changeover_drive;
      logic [5:0] unused;
   } psd_ctrl_type;

   // High-time count in the upper byte, period count in the lower byte.
   typedef struct packed {
      logic [7:0] high_time_count;
      logic [7:0] period_count;
   } psd_thtp_type;

   // ------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------

   localparam logic [15:0] PSD_CTRL_RESET  = 16'h0000;
   localparam logic [15:0] PSD_THTP_RESET  = 16'h0000;
   localparam logic [5:0]  PSD_UNUSED_READ = 6'h00;
   localparam logic [7:0]  PSD_COUNT_RESET = 8'h00;
   localparam logic [7:0]  PSD_COUNT_ONE   = 8'h01;

   // Input-rate codes 0 to 2 need the fast internal clock; the rest do not.
   localparam logic [2:0]  PSD_LAST_FAST_RATE = 3'h2;
   localparam int          PSD_RATE_COUNT     = 8;
   localparam int          PSD_USER_PINS      = 4;

   // Input rates in kHz, indexed by the input-rate select code.
   localparam real PSD_RATE_KHZ [PSD_RATE_COUNT] =
      '{4915.2, 2457.6, 1228.8, 32.768, 8.192, 1.024, 0.256, 0.032};

   // Clock of the block in MHz; every rate above is slower than it.
   localparam real PSD_MCLK_MHZ = 20.0;

endpackage : psd_pkg

// ### logic/psd_pwm_switch_driver.sv
// Eight-bit pulse-width modulator with analog, changeover and user-pin drive.
// Assumes the serial register port decodes its own address and gives one-cycle
// write strobes, and that all rate ticks and switch inputs are synchronous to mclk.

`timescale 1ns/1ps

module psd_pwm_switch_driver
   import psd_pkg::*;
(
   input  wire logic                  mclk,                      // Block clock, 20 MHz.
   input  wire logic                  rst,                       // Asynchronous reset, active high.
   input  wire logic                  ctrl_wr,                   // One-cycle write strobe, control register.
   input  wire logic                  thtp_wr,                   // One-cycle write strobe, high-time and period.
   input  wire logic [15:0]           wdata,                     // Write data for either register.
   output psd_pkg::psd_ctrl_type      ctrl_rdata,                // Control register read value.
   output psd_pkg::psd_thtp_type      thtp_rdata,                // High-time and period read value.
   input  wire logic [7:0]            rate_tick,                 // One-cycle ticks, one per input rate.
   input  wire logic                  sleep_mode,                // High while the device sleeps.
   input  wire logic                  sleep_run_enable,          // Sleep-run bit from the sleep setup.
   input  wire logic [1:0]            first_changeover_setting,  // Static setting of first changeover.
   input  wire logic                  first_changeover_pin_req,  // User pin request for first changeover.
   input  wire logic [1:0]            second_changeover_setting, // Static setting of second changeover.
   input  wire logic                  second_changeover_pin_req, // User pin request for second changeover.
   input  wire logic [3:0]            user_pin_pwm_sel,          // Pins whose mode is modulator output.
   input  wire logic [3:0]            user_pin_assert_level,     // Per-pin assertion level.
   output logic                       pwm_out,                   // True modulator phase, high when on.
   output logic                       analog_switch_a,           // High closes switch A.
   output logic                       switch_a_pwm_active,       // High while modulator controls A.
   output logic                       analog_switch_b,           // High closes switch B.
   output logic                       switch_b_pwm_active,       // High while modulator controls B.
   output logic                       first_changeover_switch,   // First changeover position.
   output logic                       second_changeover_switch,  // Second changeover position.
   output logic [3:0]                 user_pin,                  // Driven level of each user pin.
   output logic [3:0]                 user_pin_drive             // High where the modulator drives a pin.
);
   import psd_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------

   psd_ctrl_type ctrl_reg;
   psd_thtp_type thtp_reg;
   logic [7:0]   count_reg;
   logic [7:0]   count_next;
   logic         pwm_on_reg;
   logic         pwm_on_next;
   logic         run_en;
   logic         rate_ok;
   logic         run_ok;
   logic         tick;

   // Writes land whole; the unused low bits are dropped so they read zero.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg <= psd_ctrl_type'(PSD_CTRL_RESET);
      end
      else if (ctrl_wr)
      begin
         ctrl_reg <= psd_ctrl_type'({wdata[15:6], PSD_UNUSED_READ});
      end
   end

   // A new count pair lands whole, so high time and period never mix old and new.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         thtp_reg <= psd_thtp_type'(PSD_THTP_RESET);
      end
      else if (thtp_wr)
      begin
         thtp_reg <= psd_thtp_type'(wdata);
      end
   end

   // Read values come straight from the flops.
   assign ctrl_rdata = ctrl_reg;
   assign thtp_rdata = thtp_reg;

   // ------------------------------------------------------------
   // Modulator core
   // ------------------------------------------------------------

   // In sleep the sleep-run bit takes over; fast rates die with the fast clock.
   assign run_en  = sleep_mode ? sleep_run_enable : ctrl_reg.modulator_enable;
   assign rate_ok = !(sleep_mode && (ctrl_reg.input_rate_select <= PSD_LAST_FAST_RATE));
   assign run_ok  = run_en && rate_ok;
   assign tick    = rate_tick[ctrl_reg.input_rate_select];

   // A period shortened below the running count ends at the next tick rather
   // than running on through 255, which keeps a rewrite glitch to one period.
   always_comb
   begin
      count_next = count_reg;
      if (!run_ok)
      begin
         count_next = PSD_COUNT_RESET;
      end
      else if (tick)
      begin
         if (count_reg >= thtp_reg.period_count)
         begin
            count_next = PSD_COUNT_RESET;
         end
         else
         begin
            count_next = count_reg + PSD_COUNT_ONE;
         end
      end
   end

   // On phase covers counts zero through the high-time count; a zero high-time count gives no on phase.
   always_comb
   begin
      pwm_on_next = run_ok
                 && (thtp_reg.high_time_count != PSD_COUNT_RESET)
                 && (count_next <= thtp_reg.high_time_count);
   end

   // Period counter.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         count_reg <= PSD_COUNT_RESET;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   // Phase flop, so the output never glitches while the count settles.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pwm_on_reg <= 1'b0;
      end
      else
      begin
         pwm_on_reg <= pwm_on_next;
      end
   end

   assign pwm_out = pwm_on_reg;

   // ------------------------------------------------------------
   // Switch drive
   // ------------------------------------------------------------

   // Analog switches: the drive bits pick the phase that closes the switch.
   // With both bits equal the switch is left open and flagged as not driven.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         analog_switch_a     <= 1'b0;
         switch_a_pwm_active <= 1'b0;
         analog_switch_b     <= 1'b0;
         switch_b_pwm_active <= 1'b0;
      end
      else
      begin
         switch_a_pwm_active <= ctrl_reg.switch_a_high_drive ^ ctrl_reg.switch_a_low_drive;
         analog_switch_a     <= (ctrl_reg.switch_a_high_drive && !ctrl_reg.switch_a_low_drive
                                 && pwm_on_reg)
                             || (ctrl_reg.switch_a_low_drive && !ctrl_reg.switch_a_high_drive
                                 && !pwm_on_reg);
         switch_b_pwm_active <= ctrl_reg.switch_b_high_drive ^ ctrl_reg.switch_b_low_drive;
         analog_switch_b     <= (ctrl_reg.switch_b_high_drive && !ctrl_reg.switch_b_low_drive
                                 && pwm_on_reg)
                             || (ctrl_reg.switch_b_low_drive && !ctrl_reg.switch_b_high_drive
                                 && !pwm_on_reg);
      end
   end

   // Changeover switches take no inversion; the true phase is ORed in with bit 0
   // of the static setting and any pin request. Polarity is set by external wiring.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         first_changeover_switch  <= 1'b0;
         second_changeover_switch <= 1'b0;
      end
      else
      begin
         first_changeover_switch  <= first_changeover_setting[0] || first_changeover_pin_req
                                  || (ctrl_reg.first_changeover_drive && pwm_on_reg);
         second_changeover_switch <= second_changeover_setting[0] || second_changeover_pin_req
                                  || (ctrl_reg.second_changeover_drive && pwm_on_reg);
      end
   end

   // User pins: the on phase shows as the pin's assertion level.
   generate
      for (genvar p = 0; p < PSD_USER_PINS; p++)
      begin : g_user_pin
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               user_pin[p]       <= 1'b0;
               user_pin_drive[p] <= 1'b0;
            end
            else
            begin
               user_pin_drive[p] <= user_pin_pwm_sel[p];
               user_pin[p]       <= pwm_on_reg ? user_pin_assert_level[p]
                                               : !user_pin_assert_level[p];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------

   // Checks run on the block clock and rest while reset is high.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_idle_off_clear: assert property (!run_ok |=> (!pwm_out && count_reg == PSD_COUNT_RESET))
      else $error("Modulator not off while stopped.");

   a_sleep_run_swap: assert property ((sleep_mode && !sleep_run_enable) |=> !pwm_out)
      else $error("Modulator ran in sleep with sleep-run clear.");

   a_zero_high_off: assert property ((thtp_reg.high_time_count == PSD_COUNT_RESET && !thtp_wr)
                                     |=> !pwm_out)
      else $error("Output on with zero high-time.");

   a_full_duty_on: assert property ((run_ok && !thtp_wr && !ctrl_wr && !sleep_mode
                                     && thtp_reg.period_count != PSD_COUNT_RESET
                                     && thtp_reg.high_time_count >= thtp_reg.period_count
                                     && count_reg <= thtp_reg.period_count) |=> pwm_out)
      else $error("Output off at full duty.");

   a_count_wraps: assert property ((run_ok && tick && count_reg >= thtp_reg.period_count
                                    && !ctrl_wr && !sleep_mode)
                                   |=> (count_reg == PSD_COUNT_RESET))
      else $error("Counter did not wrap after the period.");

   a_count_steps: assert property ((run_ok && tick && count_reg < thtp_reg.period_count
                                    && !ctrl_wr && !sleep_mode)
                                   |=> (count_reg == $past(count_reg) + PSD_COUNT_ONE))
      else $error("Counter did not step on a tick.");

   a_phase_matches: assert property ((run_ok && !thtp_wr && !ctrl_wr && !sleep_mode
                                      && thtp_reg.high_time_count != PSD_COUNT_RESET)
                                     |=> (pwm_out == (count_reg <= $past(thtp_reg.high_time_count))))
      else $error("Phase does not match the count.");

   a_sleep_fast_off: assert property ((sleep_mode && ctrl_reg.input_rate_select <= PSD_LAST_FAST_RATE)
                                      |=> !pwm_out)
      else $error("Fast rate produced output in sleep.");

   a_switch_a_high: assert property ((ctrl_reg.switch_a_high_drive && !ctrl_reg.switch_a_low_drive && !ctrl_wr)
                                     |=> (analog_switch_a == $past(pwm_out)))
      else $error("Switch A does not follow the on phase.");

   a_switch_a_low: assert property ((ctrl_reg.switch_a_low_drive && !ctrl_reg.switch_a_high_drive && !ctrl_wr)
                                    |=> (analog_switch_a == !$past(pwm_out)))
      else $error("Switch A does not follow the off phase.");

   a_switch_a_free: assert property ((ctrl_reg.switch_a_low_drive == ctrl_reg.switch_a_high_drive && !ctrl_wr)
                                     |=> (!switch_a_pwm_active && !analog_switch_a))
      else $error("Switch A driven with equal drive bits.");

   a_switch_b_high: assert property ((ctrl_reg.switch_b_high_drive && !ctrl_reg.switch_b_low_drive && !ctrl_wr)
                                     |=> (analog_switch_b == $past(pwm_out)))
      else $error("Switch B does not follow the on phase.");

   a_switch_b_low: assert property ((ctrl_reg.switch_b_low_drive && !ctrl_reg.switch_b_high_drive && !ctrl_wr)
                                    |=> (analog_switch_b == !$past(pwm_out)))
      else $error("Switch B does not follow the off phase.");

   a_switch_b_free: assert property ((ctrl_reg.switch_b_low_drive == ctrl_reg.switch_b_high_drive && !ctrl_wr)
                                     |=> (!switch_b_pwm_active && !analog_switch_b))
      else $error("Switch B driven with equal drive bits.");

   a_changeover_one: assert property ((ctrl_reg.first_changeover_drive && pwm_out && !ctrl_wr)
                                      |=> first_changeover_switch)
      else $error("First changeover ignores the on phase.");

   a_changeover_two: assert property ((!ctrl_reg.second_changeover_drive && !ctrl_wr
                                       && second_changeover_setting == 2'h0 && !second_changeover_pin_req)
                                      |=> !second_changeover_switch)
      else $error("Second changeover driven without a source.");

   a_user_pin_level: assert property (pwm_out |=> (user_pin == $past(user_pin_assert_level)))
      else $error("User pin on level wrong.");

   a_tick_gates_count: assert property ((run_ok && !tick) |=> $stable(count_reg))
      else $error("Counter moved without a selected tick.");

   a_pin_drive_copy: assert property (1'b1 |=> (user_pin_drive == $past(user_pin_pwm_sel)))
      else $error("User pin drive does not follow the pin selection.");

   a_changeover_setting: assert property ((first_changeover_setting[0] || first_changeover_pin_req)
                                          |=> first_changeover_switch)
      else $error("First changeover ignores its setting or pin request.");

   c_period_wrap: cover property (run_ok && tick && count_reg == thtp_reg.period_count
                                  && thtp_reg.period_count != PSD_COUNT_RESET);
   c_full_duty: cover property (pwm_out [*8]);
   c_sleep_run: cover property (sleep_mode && sleep_run_enable && pwm_out);
   c_inverted_a: cover property (ctrl_reg.switch_a_low_drive && !ctrl_reg.switch_a_high_drive && analog_switch_a);
   c_fast_in_sleep: cover property (sleep_mode && ctrl_reg.modulator_enable
                                    && ctrl_reg.input_rate_select <= PSD_LAST_FAST_RATE);

endmodule : psd_pwm_switch_driver

// ### testbench/psd_testbench.sv
// Self-checking bench for the pulse-width modulator and switch driver.
// Assumes psd_pkg is compiled first; the bench drives every design input itself.

`timescale 1ns/1ps

module testbench;
   import psd_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic               mclk, rst, ctrl_wr, thtp_wr, sleep_mode, sleep_run_enable;
   logic [15:0]        wdata;
   psd_ctrl_type       ctrl_rdata, m_ctrl;
   psd_thtp_type       thtp_rdata, m_thtp;
   logic [7:0]         rate_tick, tick_mask;
   logic [1:0]         first_changeover_setting, second_changeover_setting;
   logic               first_changeover_pin_req, second_changeover_pin_req;
   logic [3:0]         user_pin_pwm_sel, user_pin_assert_level, user_pin, user_pin_drive, m_up, m_upd;
   logic               pwm_out, analog_switch_a, switch_a_pwm_active, analog_switch_b, switch_b_pwm_active;
   logic               first_changeover_switch, second_changeover_switch;
   logic               m_pwm, m_sa, m_saa, m_sb, m_sba, m_c1, m_c2, run_m;
   int                 m_cnt, nc_m, err_total, checked, cyc, ones, i;
   int unsigned        seed_v;
   logic [15:0]        edge_v [7] = '{16'h0005, 16'h0505, 16'hff03, 16'h0300, 16'h0000, 16'h0103, 16'h02ff};

   psd_pwm_switch_driver i_dut (.mclk(mclk), .rst(rst), .ctrl_wr(ctrl_wr), .thtp_wr(thtp_wr), .wdata(wdata),
      .ctrl_rdata(ctrl_rdata), .thtp_rdata(thtp_rdata), .rate_tick(rate_tick), .sleep_mode(sleep_mode),
      .sleep_run_enable(sleep_run_enable), .first_changeover_setting(first_changeover_setting),
      .first_changeover_pin_req(first_changeover_pin_req), .second_changeover_setting(second_changeover_setting),
      .second_changeover_pin_req(second_changeover_pin_req), .user_pin_pwm_sel(user_pin_pwm_sel),
      .user_pin_assert_level(user_pin_assert_level), .pwm_out(pwm_out), .analog_switch_a(analog_switch_a),
      .switch_a_pwm_active(switch_a_pwm_active), .analog_switch_b(analog_switch_b),
      .switch_b_pwm_active(switch_b_pwm_active), .first_changeover_switch(first_changeover_switch),
      .second_changeover_switch(second_changeover_switch), .user_pin(user_pin), .user_pin_drive(user_pin_drive));

   // ------------------------------------------------------------
   // Clock, timeout and reporting
   // ------------------------------------------------------------

   // Clock at 20 MHz.
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // A hang is cut short well beyond the few thousand cycles the tests need.
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         err_total++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d.", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // Reference model
   // ------------------------------------------------------------

   // Registers, counter and the one-cycle-late switch and pin outputs.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         m_ctrl <= PSD_CTRL_RESET;
         m_thtp <= PSD_THTP_RESET;
         m_cnt  <= 0;
         {m_pwm, m_sa, m_saa, m_sb, m_sba, m_c1, m_c2, m_up, m_upd} <= '0;
      end
      else
      begin
         // Fast rates stop in sleep because the fast clock is gone there.
         run_m = (sleep_mode ? sleep_run_enable : m_ctrl.modulator_enable) &&
                 !(sleep_mode && m_ctrl.input_rate_select <= PSD_LAST_FAST_RATE);
         nc_m = m_cnt;
         if (!run_m)
            nc_m = 0;
         else if (rate_tick[m_ctrl.input_rate_select])
            nc_m = (m_cnt >= int'(m_thtp.period_count)) ? 0 : m_cnt + 1;
         m_cnt  <= nc_m;
         m_pwm  <= run_m && m_thtp.high_time_count != 8'h00 && nc_m <= int'(m_thtp.high_time_count);
         m_saa  <= m_ctrl.switch_a_high_drive ^ m_ctrl.switch_a_low_drive;
         m_sa   <= m_ctrl.switch_a_high_drive ? (m_pwm & ~m_ctrl.switch_a_low_drive)
                                              : (~m_pwm & m_ctrl.switch_a_low_drive);
         m_sba  <= m_ctrl.switch_b_high_drive ^ m_ctrl.switch_b_low_drive;
         m_sb   <= m_ctrl.switch_b_high_drive ? (m_pwm & ~m_ctrl.switch_b_low_drive)
                                              : (~m_pwm & m_ctrl.switch_b_low_drive);
         m_c1   <= first_changeover_setting[0] | first_changeover_pin_req |
                   (m_ctrl.first_changeover_drive & m_pwm);
         m_c2   <= second_changeover_setting[0] | second_changeover_pin_req |
                   (m_ctrl.second_changeover_drive & m_pwm);
         m_up   <= m_pwm ? user_pin_assert_level : ~user_pin_assert_level;
         m_upd  <= user_pin_pwm_sel;
         if (ctrl_wr)
            m_ctrl <= {wdata[15:6], PSD_UNUSED_READ};
         if (thtp_wr)
            m_thtp <= wdata;
      end
   end

   // Every settled output is compared with the model on each falling edge.
   always @(negedge mclk)
   begin
      if (!rst)
      begin
         chk(ctrl_rdata, m_ctrl);
         chk(thtp_rdata, m_thtp);
         chk({15'h0, pwm_out}, {15'h0, m_pwm});
         chk({14'h0, switch_a_pwm_active, switch_b_pwm_active}, {14'h0, m_saa, m_sba});
         chk({15'h0, analog_switch_a}, {15'h0, m_sa});
         chk({15'h0, analog_switch_b}, {15'h0, m_sb});
         chk({14'h0, first_changeover_switch, second_changeover_switch}, {14'h0, m_c1, m_c2});
         chk({8'h0, user_pin, user_pin_drive}, {8'h0, m_up, m_upd});
      end
   end

   // ------------------------------------------------------------
   // Stimulus tasks
   // ------------------------------------------------------------

   // Free-running inputs change at the falling edge, away from sampling.
   task automatic step(input int n);
      repeat (n)
      begin
         @(negedge mclk);
         rate_tick                 = 8'($urandom) & tick_mask;
         first_changeover_setting  = 2'($urandom);
         second_changeover_setting = 2'($urandom);
         first_changeover_pin_req  = ($urandom % 4) == 0;
         second_changeover_pin_req = ($urandom % 4) == 0;
         user_pin_pwm_sel          = 4'($urandom);
         user_pin_assert_level     = 4'($urandom);
      end
   endtask : step

   task automatic wr_reg(input logic sel_ctrl, input logic [15:0] v);
      @(negedge mclk);
      ctrl_wr = sel_ctrl;
      thtp_wr = ~sel_ctrl;
      wdata   = v;
      @(negedge mclk);
      ctrl_wr = 1'b0;
      thtp_wr = 1'b0;
   endtask : wr_reg

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {rst, ctrl_wr, thtp_wr, sleep_mode, sleep_run_enable} = 5'b10000;
      {wdata, rate_tick, first_changeover_setting, second_changeover_setting} = '0;
      {first_changeover_pin_req, second_changeover_pin_req, user_pin_pwm_sel, user_pin_assert_level} = '0;
      {err_total, checked, cyc, ones} = '0;
      tick_mask = 8'hff;
      seed_v = $urandom(32'hdad1d6a2);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      chk(ctrl_rdata, PSD_CTRL_RESET);
      chk(thtp_rdata, PSD_THTP_RESET);
      $display("Test reset values done, %0d mismatches.", err_total);

      // Every rate code with random counts, switch bits and unused low bits.
      for (i = 0; i < PSD_RATE_COUNT; i++)
      begin
         wr_reg(1'b0, 16'($urandom));
         wr_reg(1'b1, {1'b1, 3'(i), 12'($urandom)});
         step(300);
      end
      $display("Test rate codes done, %0d mismatches.", err_total);

      // Boundary counts, equal drive bits, then a stop in mid-period.
      foreach (edge_v[k])
      begin
         wr_reg(1'b0, edge_v[k]);
         wr_reg(1'b1, (k % 2) ? 16'h8cc0 : 16'h89c0);
         step(40);
      end
      wr_reg(1'b1, 16'h09c0);
      step(20);
      $display("Test boundaries done, %0d mismatches.", err_total);

      // High time 1 over period 3 with a tick every cycle gives half on.
      wr_reg(1'b0, 16'h0103);
      rate_tick = 8'hff;
      wr_reg(1'b1, 16'h8000);
      repeat (40)
      begin
         @(negedge mclk);
         if (pwm_out === 1'b1)
            ones++;
      end
      chk(16'(ones), 16'd20);
      $display("Test duty done, %0d mismatches.", err_total);

      // Sleep: the sleep-run bit rules, and fast rates give nothing.
      sleep_mode       = 1'b1;
      sleep_run_enable = 1'b1;
      tick_mask        = 8'hf8;
      wr_reg(1'b1, 16'h3a00);
      step(60);
      wr_reg(1'b1, 16'h8a00);
      step(40);
      chk({15'h0, pwm_out}, 16'h0000);
      sleep_run_enable = 1'b0;
      wr_reg(1'b1, 16'hba00);
      step(40);
      chk({15'h0, pwm_out}, 16'h0000);
      sleep_mode = 1'b0;
      tick_mask  = 8'hff;
      step(40);
      $display("Test sleep done, %0d mismatches.", err_total);
      wrap_up();
   end

endmodule : testbench
